// >>> hdl/uart_pins_pkg.sv
package uart_pins_pkg;
  // ---------------------------------------------------------------
  // timing and framing constants
  // ---------------------------------------------------------------
  localparam int unsigned CLOCK_HZ       = 10_000_000;  // system clock rate
  localparam int unsigned BAUD_DEFAULT   = 9_600;       // default line rate
  localparam int unsigned DATA_BITS      = 8;           // character width
  localparam int unsigned QUEUE_DEPTH    = 4;           // receive queue entries
  localparam int unsigned RTS_HIGH_MARK  = 3;           // negate request at or above
  localparam int unsigned RTS_LOW_MARK   = 1;           // assert request at or below
  localparam logic        LINE_MARK      = 1'b1;        // idle line level
  localparam logic        LINE_SPACE     = 1'b0;        // start bit level
endpackage

// >>> hdl/uart_serial_pins.sv
// Notes on behaviour
// RULE1 - tx line high when disabled, idle, loopback
// RULE2 - send lsb first, change on falling edge
// RULE3 - receive characters assembled lsb first
// RULE4 - any rx transition restarts stopped clock
// RULE5 - clear to send permits starting a character
// RULE6 - request to send from software or queue level
// RULE7 - one start bit, data, one stop bit
module uart_serial_pins
  import uart_pins_pkg::*;
#(
  parameter int unsigned CLOCK_RATE = CLOCK_HZ,
  parameter int unsigned BAUD       = BAUD_DEFAULT,
  parameter int unsigned DEPTH      = QUEUE_DEPTH,
  parameter int unsigned HIGH_MARK  = RTS_HIGH_MARK,
  parameter int unsigned LOW_MARK   = RTS_LOW_MARK
) (
  input  wire logic                 clock,
  input  wire logic                 sys_rst,
  input  wire logic                 txEnable,      // transmitter enable
  input  wire logic                 loopback,      // local loopback mode
  input  wire logic                 powerDown,     // request to stop clock
  input  wire logic                 autoRts,       // request follows queue level
  input  wire logic                 softRts,       // software request level
  input  wire logic [DATA_BITS-1:0] txData,
  input  wire logic                 txValid,
  output logic                      txReady,
  output logic [DATA_BITS-1:0]      rxData,
  output logic                      rxValid,
  input  wire logic                 rxReady,
  output logic                      clockRunning,  // channel clock not stopped
  output logic [3:0]                rxLevel,       // receive queue fill
  input  wire logic                 serial_rx_in,
  input  wire logic                 clear_to_send_in,   // active high permit
  output logic                      serial_tx_out,
  output logic                      request_to_send_out
);
  // ---------------------------------------------------------------
  // bit timing
  // ---------------------------------------------------------------
  localparam int unsigned DIV  = (CLOCK_RATE / BAUD) < 2 ? 2 : CLOCK_RATE / BAUD;
  localparam int unsigned HALF = DIV / 2;
  localparam logic [15:0] DIV_M1  = 16'(DIV - 1);
  localparam logic [15:0] HALF_M1 = 16'(HALF - 1);
  localparam logic [15:0] HALF_AT = 16'(HALF);

  typedef enum {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_e;
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_e;

  // ---------------------------------------------------------------
  // power-down clock gate
  // ---------------------------------------------------------------
  logic rxPrev;       // last sampled rx level
  logic pdPrev;       // stop on a new request only, so a line wake sticks
  logic next_clockRunning;
  always_comb begin
    next_clockRunning = clockRunning;
    if (powerDown && !pdPrev) begin
      next_clockRunning = 1'b0;
    end else if (!clockRunning && (serial_rx_in != rxPrev)) begin
      next_clockRunning = 1'b1;  // [RULE4]
    end else if (!powerDown) begin
      next_clockRunning = 1'b1;
    end
  end
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      clockRunning <= 1'b1;
      rxPrev       <= LINE_MARK;
      pdPrev       <= 1'b0;
    end else begin
      clockRunning <= next_clockRunning;
      rxPrev       <= serial_rx_in;
      pdPrev       <= powerDown;
    end
  end

  // ---------------------------------------------------------------
  // transmitter
  // ---------------------------------------------------------------
  tx_state_e txState, next_txState;
  logic [15:0]          txCnt, next_txCnt;     // cycles into bit
  logic [2:0]           txBit, next_txBit;     // data bit index
  logic [DATA_BITS-1:0] txShift, next_txShift; // shift register
  logic                 txLine, next_txLine;   // registered line level
  // after the start bit the line is only updated at the end of a bit period, which plays
  // the role of the falling edge of the serial clock source
  always_comb begin
    next_txState = txState;
    next_txCnt   = txCnt;
    next_txBit   = txBit;
    next_txShift = txShift;
    next_txLine  = txLine;
    txReady      = 1'b0;
    case (txState)
      TX_IDLE: begin
        next_txLine = LINE_MARK;  // [RULE1]
        txReady = txEnable && !loopback && clear_to_send_in && clockRunning;  // [RULE5]
        if (txValid && txReady) begin
          next_txShift = txData;
          next_txCnt   = '0;
          next_txLine  = LINE_SPACE;  // [RULE7]
          next_txState = TX_START;
        end
      end
      TX_START, TX_DATA, TX_STOP: begin
        if (!clockRunning) begin
          next_txCnt = txCnt;
        end else if (txCnt != DIV_M1) begin
          next_txCnt = txCnt + 16'h0001;
        end else begin
          next_txCnt = '0;
          case (txState)
            TX_START: begin
              next_txLine  = txShift[0];  // [RULE2]
              next_txShift = txShift >> 1;
              next_txBit   = '0;
              next_txState = TX_DATA;
            end
            TX_DATA: begin
              if (txBit == 3'(DATA_BITS - 1)) begin
                next_txLine  = LINE_MARK;  // [RULE7]
                next_txState = TX_STOP;
              end else begin
                next_txLine  = txShift[0];  // [RULE2]
                next_txShift = txShift >> 1;
                next_txBit   = txBit + 3'h1;
              end
            end
            default: begin
              next_txLine  = LINE_MARK;
              next_txState = TX_IDLE;
            end
          endcase
        end
      end
      default: next_txState = TX_IDLE;
    endcase
  end
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      txState <= TX_IDLE;
      txCnt   <= '0;
      txBit   <= '0;
      txShift <= '0;
      txLine  <= LINE_MARK;
    end else begin
      txState <= next_txState;
      txCnt   <= next_txCnt;
      txBit   <= next_txBit;
      txShift <= next_txShift;
      txLine  <= next_txLine;
    end
  end
  // loopback keeps the pin at mark whatever the shifter does
  assign serial_tx_out = (loopback || !txEnable) ? LINE_MARK : txLine;  // [RULE1]
  // loopback feeds the shifter back to the receiver
  logic rxLine;
  assign rxLine = loopback ? txLine : serial_rx_in;

  // ---------------------------------------------------------------
  // receiver
  // ---------------------------------------------------------------
  rx_state_e rxState, next_rxState;
  logic [15:0]          rxCnt, next_rxCnt;
  logic [2:0]           rxBit, next_rxBit;
  logic [DATA_BITS-1:0] rxShift, next_rxShift;
  logic                 pushValid;  // completed character
  logic                 pushReady;  // queue has room
  always_comb begin
    next_rxState = rxState;
    next_rxCnt   = rxCnt;
    next_rxBit   = rxBit;
    next_rxShift = rxShift;
    pushValid    = 1'b0;
    case (rxState)
      RX_IDLE: begin
        next_rxCnt = '0;
        if (clockRunning && rxLine == LINE_SPACE) begin
          next_rxState = RX_START;
        end
      end
      RX_START: begin
        // re-check start at mid bit to reject glitches
        if (rxCnt != HALF_M1) begin
          next_rxCnt = rxCnt + 16'h0001;
        end else begin
          next_rxCnt   = '0;
          next_rxBit   = '0;
          next_rxState = (rxLine == LINE_SPACE) ? RX_DATA : RX_IDLE;  // [RULE7]
        end
      end
      RX_DATA: begin
        if (rxCnt != DIV_M1) begin
          next_rxCnt = rxCnt + 16'h0001;
        end else begin
          next_rxCnt   = '0;
          next_rxShift = {rxLine, rxShift[DATA_BITS-1:1]};  // [RULE3]
          next_rxBit   = rxBit + 3'h1;
          if (rxBit == 3'(DATA_BITS - 1)) begin
            next_rxState = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (rxCnt != DIV_M1) begin
          next_rxCnt = rxCnt + 16'h0001;
        end else begin
          // framing error (low stop) drops the character
          pushValid    = (rxLine == LINE_MARK);  // [RULE7]
          next_rxState = RX_IDLE;
        end
      end
      default: next_rxState = RX_IDLE;
    endcase
  end
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rxState <= RX_IDLE;
      rxCnt   <= '0;
      rxBit   <= '0;
      rxShift <= '0;
    end else begin
      rxState <= next_rxState;
      rxCnt   <= next_rxCnt;
      rxBit   <= next_rxBit;
      rxShift <= next_rxShift;
    end
  end

  // ---------------------------------------------------------------
  // receive queue, a ring of DEPTH words
  // ---------------------------------------------------------------
  // a character arriving while full is lost: the line cannot stall,
  // which is why the request output throttles the far side early
  localparam int unsigned AW = (DEPTH < 2) ? 1 : $clog2(DEPTH);
  logic [DATA_BITS-1:0] mem [DEPTH];
  logic [AW-1:0]        wrPtr, next_wrPtr, rdPtr, next_rdPtr;
  logic [3:0]           count, next_count;
  logic                 doPush, doPop;
  assign pushReady = (count != 4'(DEPTH));
  assign doPush    = pushValid && pushReady;
  assign doPop     = rxValid && rxReady;
  assign rxValid   = (count != 4'h0);
  assign rxLevel   = count;
  always_comb begin
    next_wrPtr = wrPtr;
    next_rdPtr = rdPtr;
    next_count = count;
    if (doPush) begin
      next_wrPtr = (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + AW'(1);
    end
    if (doPop) begin
      next_rdPtr = (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + AW'(1);
    end
    if (doPush && !doPop) begin
      next_count = count + 4'h1;
    end else if (doPop && !doPush) begin
      next_count = count - 4'h1;
    end
  end
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
    end
    if (doPush) begin
      mem[wrPtr] <= rxShift;
    end
  end
  always_comb rxData = mem[rdPtr];

  // ---------------------------------------------------------------
  // request-to-send (active high = request)
  // ---------------------------------------------------------------
  // hysteresis between the two marks avoids chatter on the pin
  logic autoReq, next_autoReq;
  always_comb begin
    next_autoReq = autoReq;
    if (count >= 4'(HIGH_MARK)) begin
      next_autoReq = 1'b0;  // [RULE6]
    end else if (count <= 4'(LOW_MARK)) begin
      next_autoReq = 1'b1;  // [RULE6]
    end
  end
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      autoReq <= 1'b1;
    end else begin
      autoReq <= next_autoReq;
    end
  end
  assign request_to_send_out = autoRts ? autoReq : softRts;  // [RULE6]
endmodule

// >>> verification/uart_serial_pins_chk.sv
module uart_serial_pins_chk
  import uart_pins_pkg::*;
#(
  parameter int unsigned CLOCK_RATE = CLOCK_HZ,
  parameter int unsigned BAUD       = BAUD_DEFAULT,
  parameter int unsigned HIGH_MARK  = RTS_HIGH_MARK,
  parameter int unsigned LOW_MARK   = RTS_LOW_MARK
) (
  input wire logic       clock,
  input wire logic       sys_rst,
  input wire logic       txEnable,
  input wire logic       loopback,
  input wire logic       autoRts,
  input wire logic       softRts,
  input wire logic       txValid,
  input wire logic       txReady,
  input wire logic       clockRunning,
  input wire logic [3:0] rxLevel,
  input wire logic       serial_rx_in,
  input wire logic       clear_to_send_in,
  input wire logic       serial_tx_out,
  input wire logic       request_to_send_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // line and handshake checks
  // ---------------------------------------------------------------
  localparam int STOP_AT = 1 + 9 * (CLOCK_RATE / BAUD);  // take edge to stop bit
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // a character handed over
  sequence s_take;
    txValid && txReady;
  endsequence
  // start bit held low for most of a bit time
  sequence s_start;
    (!serial_tx_out) [*8];
  endsequence
  a_mark_when_idle: assert property ((!txEnable || loopback) |-> serial_tx_out)
    else $error("tx line not at mark");
  // nothing to send: an idle, permitted transmitter shows mark
  a_mark_when_ready: assert property (txReady |-> serial_tx_out)
    else $error("idle tx line not at mark");
  a_start_bit_low: assert property (s_take ##1 (txEnable && !loopback) |-> s_start)
    else $error("start bit missing after take");
  a_stop_bit_high: assert property (s_take |-> ##STOP_AT serial_tx_out)
    else $error("stop bit not high");
  a_ready_needs_cts: assert property (txReady |-> clear_to_send_in && clockRunning)
    else $error("ready without permit");
  a_rx_edge_wakes: assert property (!clockRunning && $changed(serial_rx_in)
    |-> ##[0:3] clockRunning)
    else $error("line edge did not restart clock");
  a_rts_full_drop: assert property (autoRts && rxLevel >= HIGH_MARK ##1 autoRts
    |-> !request_to_send_out)
    else $error("request not dropped at high fill");
  a_rts_empty_raise: assert property (autoRts && rxLevel <= LOW_MARK ##1 autoRts
    |-> request_to_send_out)
    else $error("request not raised at low fill");
  a_rts_soft_follow: assert property (!autoRts |-> request_to_send_out == softRts)
    else $error("request does not follow software level");
endmodule
bind uart_serial_pins uart_serial_pins_chk #(.CLOCK_RATE(CLOCK_RATE), .BAUD(BAUD),
  .HIGH_MARK(HIGH_MARK), .LOW_MARK(LOW_MARK)) chk (.*);

// >>> verification/remote_serial_model.sv
module remote_serial_model #(
  parameter int DIV = 10  // clock cycles per bit, same rate both ways
) (
  input  wire logic clock,
  input  wire logic txLine,  // line from the channel
  output logic      rxLine   // line into the channel
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got;      // last character decoded
  logic       stopBit;  // its stop bit sample
  initial rxLine = 1'b1;
  // one frame out, start, data lsb first, stop
  task automatic send_char(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxLine = f[i];
      repeat (DIV) @(negedge clock);
    end
  endtask
  // decoder samples mid bit, lsb arrives first
  always begin
    @(negedge txLine);
    repeat (DIV + DIV / 2) @(posedge clock);
    for (int i = 0; i < 8; i++) begin
      got[i] = txLine;
      repeat (DIV) @(posedge clock);
    end
    stopBit = txLine;
  end
endmodule

// >>> verification/uart_serial_pins_tb_top.sv
module uart_serial_pins_tb_top
  import uart_pins_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // stimulus, partner and checks
  // ---------------------------------------------------------------
  localparam int DIV = 10;  // short bits keep the run brief
  logic clock = 1'b0;
  logic sys_rst, txEnable, loopback, powerDown, autoRts, softRts, seen;
  logic txValid, txReady, rxValid, rxReady, clockRunning;
  logic serial_rx_in, clear_to_send_in, serial_tx_out, request_to_send_out;
  logic [7:0] txData, rxData;
  logic [3:0] rxLevel;
  int errors = 0, nCompared = 0, cycles = 0;
  logic [7:0] chars [5] = '{8'h01, 8'h80, 8'ha5, 8'h5a, 8'hff};
  logic [2:0] modes [3] = '{3'b001, 3'b111, 3'b100};  // enable, loopback, cts
  uart_serial_pins #(.BAUD(CLOCK_HZ / DIV)) uut (.*);
  remote_serial_model #(.DIV(DIV)) model (.clock, .txLine(serial_tx_out),
    .rxLine(serial_rx_in));
  initial forever #50 clock = ~clock;
  // hang guard, well above the expected run
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      report_and_stop();
    end
  end
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    nCompared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_bit(input string what, input logic exp, input logic got);
    check(what, {7'h0, exp}, {7'h0, got});
  endtask
  // offer a character and hold it until taken; ready is read at the
  // falling edge where it is settled, never in the taking edge's step
  task automatic send(input logic [7:0] b);
    int n;
    n = 0;
    @(negedge clock);
    txData = b;
    txValid = 1'b1;
    while (txReady !== 1'b1 && n < 500) begin
      @(negedge clock);
      n++;
    end
    @(negedge clock);
    txValid = 1'b0;
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", nCompared, errors);
    if (errors == 0 && nCompared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    {txEnable, loopback, powerDown, autoRts, softRts, txValid, rxReady} = '0;
    clear_to_send_in = 1'b1;
    txData = '0;
    sys_rst = 1'b1;
    repeat (6) @(negedge clock);
    sys_rst = 1'b0;
    // disabled, loopback and no permit all keep the line at mark
    txValid = 1'b1;
    for (int m = 0; m < 3; m++) begin
      {txEnable, loopback, clear_to_send_in} = modes[m];
      repeat (3) @(negedge clock);
      check_bit("blocked ready", 1'b0, txReady);
      check_bit("blocked line", LINE_MARK, serial_tx_out);
    end
    txValid = 1'b0;
    {txEnable, loopback, clear_to_send_in} = 3'b101;
    $display("test blocked done");
    for (int i = 0; i < 3; i++) begin
      send(chars[i]);
      repeat (11 * DIV) @(negedge clock);
      check("sent char", chars[i], model.got);
      check_bit("sent stop", LINE_MARK, model.stopBit);
    end
    $display("test transmit done");
    // receiver stalls, fifth character overflows the queue
    autoRts = 1'b1;
    for (int i = 0; i < 5; i++)
      model.send_char(chars[i]);
    repeat (DIV) @(negedge clock);
    check("queue level", 8'(QUEUE_DEPTH), {4'h0, rxLevel});
    check_bit("request dropped", 1'b0, request_to_send_out);
    for (int i = 0; i < 4; i++) begin
      check("received char", chars[i], rxData);
      rxReady = 1'b1;
      @(negedge clock);
      rxReady = 1'b0;
      @(negedge clock);
      // level two lies between the marks: the request stays low
      if (i == 1) begin
        check_bit("request held", 1'b0, request_to_send_out);
      end
    end
    check_bit("queue empty", 1'b0, rxValid);
    check_bit("request raised", 1'b1, request_to_send_out);
    $display("test receive done");
    autoRts = 1'b0;
    for (int v = 0; v < 2; v++) begin
      softRts = v[0];
      @(negedge clock);
      check_bit("soft request", v[0], request_to_send_out);
    end
    $display("test request done");
    // short low pulse, too brief for a start bit, must wake the clock
    powerDown = 1'b1;
    repeat (3) @(negedge clock);
    check_bit("clock stopped", 1'b0, clockRunning);
    model.rxLine = 1'b0;
    seen = 1'b0;
    repeat (4) begin
      @(negedge clock);
      seen = seen | clockRunning;
    end
    check_bit("clock kept", 1'b1, clockRunning);
    model.rxLine = 1'b1;
    powerDown = 1'b0;
    check_bit("woken by line", 1'b1, seen);
    $display("test wake done");
    report_and_stop();
  end
endmodule
